// [ebw_defines.svh]
`ifndef EBW_DEFINES_SVH
`define EBW_DEFINES_SVH

// register offsets (word index on the plain register port)
`define EBW_OFS_SEL_BASE     6'h00
`define EBW_OFS_FCON_BASE    6'h08
`define EBW_OFS_TCON_BASE    6'h10
`define EBW_OFS_MODE         6'h18
`define EBW_OFS_STATUS       6'h19
`define EBW_OFS_TCON_SM      6'h1A
`define EBW_OFS_TCON_MM      6'h1B

// window select layout
`define EBW_BASE_HI          15
`define EBW_BASE_LO          4
`define EBW_SIZE_HI          3
`define EBW_SIZE_LO          0
`define EBW_SIZE_MAX         4'hB

// function config layout
`define EBW_FCON_WINDOW_SELECT_ENABLE        0
`define EBW_FCON_WINDOW_READY_ENABLE       1
`define EBW_FCON_WINDOW_READY_SYNC_MODE      2
`define EBW_FCON_MASK        16'h0037
`define EBW_FCON0_RESET      16'h0021
`define EBW_FCONX_RESET      16'h0000

// timing config layout
`define EBW_TCON_PHE_HI      10
`define EBW_TCON_PHE_LO      6
`define EBW_TCON_MASK        16'h7FFF
`define EBW_TCON_RESET       16'h0000

// mode register layout
`define EBW_MODE_READY_PIN_DISABLE      0
`define EBW_MODE_READY_POLARITY      1
`define EBW_MODE_RESET       16'h0001

// hardwired windows: A23..A15 of each 32 kByte area
`define EBW_SM_TAG           9'h17E
`define EBW_MM_TAG           9'h17F

// asynchronous ready costs one synchroniser wait state
`define EBW_ASYNC_EXTRA      6'h01

`endif

// [ebw_pkg.sv]
package ebw_pkg;
   typedef logic [23:0] ebw_addr_t;
   typedef logic [15:0] ebw_word_t;
   typedef logic [3:0]  ebw_chan_t;

   // channel codes: 0 default, 1..7 windows, 8 startup, 9 monitor, 15 none
   typedef enum logic [1:0] {
      EBW_IDLE = 2'b00,
      EBW_WAIT = 2'b01,
      EBW_RDY  = 2'b10
   } ebw_state_e;
endpackage

// [ebw_cfg_if.sv]
`timescale 1ns/10ps
interface ebw_cfg_if;
   import ebw_pkg::*;
   logic [6:0][15:0] sel;
   logic [6:0]       win_en;
   ebw_addr_t        addr;
   logic [6:0]       hit;

   modport decoder (
      input  sel,
      input  win_en,
      input  addr,
      output hit
   );
   modport owner (
      output sel,
      output win_en,
      output addr,
      input  hit
   );
endinterface

// [ebw_win_match.sv]
`timescale 1ns/10ps
`include "ebw_defines.svh"
module ebw_win_match (
   ebw_cfg_if.decoder cfg
);
   import ebw_pkg::*;

   // compare mask: size code n drops the n low start bits
   function automatic logic [11:0] ebw_mask(input logic [3:0] size);
      logic [11:0] m;
      m = 12'hFFF;
      if (size > `EBW_SIZE_MAX) begin
         m = 12'h000;
      end else begin
         m = 12'(12'hFFF << size);
      end
      return m;
   endfunction

   genvar g;
   generate
      for (g = 0; g < 7; g++) begin : g_win
         logic [11:0] base;
         logic [11:0] msk;
         logic        legal;
         assign base  = cfg.sel[g][`EBW_BASE_HI:`EBW_BASE_LO];
         assign msk   = ebw_mask(cfg.sel[g][`EBW_SIZE_HI:`EBW_SIZE_LO]);
         // reserved size codes never hit
         assign legal = cfg.sel[g][`EBW_SIZE_HI:`EBW_SIZE_LO] <= `EBW_SIZE_MAX;
         // only relevant start bits meet the top address bits
         assign cfg.hit[g] = cfg.win_en[g] && legal &&
                             (((cfg.addr[23:12] ^ base) & msk) == 12'h000);
      end
   endgenerate
endmodule

// [ebw_top.sv]
`timescale 1ns/10ps
`include "ebw_defines.svh"
// How it works
// - seven programmable windows, each with own function and timing set
// - size code 0..11 gives 4 KB doubling to 8 MB; 11xx reserved
// - only size-relevant start bits compared with top address bits
// - start bits below size boundary ignored whatever their value
// - address bits below compared bits passed on to memory
// - two fixed 32 kByte channels for startup and monitor memory
// - all enabled windows compared, resolved in four priority levels
// - hardwired windows first; their range reachable by no other select
// - even windows 2,4,6 override odd windows
// - odd windows 1,3,5,7 use their own set
// - no match uses default channel 0 if enabled
// - count programmed phase E cycles, sample ready in the last
// - ready pin enabled by disable bit 0; polarity bit sets level
// - per-window ready enable and sync mode bits
// - ready-enabled cycle waits forever for active ready
// - asynchronous ready adds one wait state for synchronisation
// - synchronous ready peripheral meets setup and hold
// - disabled select drops its chip select and its window
// - mode bit 0 asynchronous, 1 synchronous
module ebw_top (
   input  wire logic            sys_clk,
   input  wire logic            rst,
   input  wire logic [5:0]      reg_addr,
   input  wire logic [15:0]     reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output logic [15:0]          reg_rdata,
   input  wire logic            req_valid,
   input  wire ebw_pkg::ebw_addr_t req_addr,
   input  wire logic            ready_pin,
   output logic                 cyc_busy,
   output logic                 cyc_done,
   output logic                 cyc_refused,
   output logic [9:0]           chip_sel,
   output logic [3:0]           cyc_chan,
   output logic [15:0]          cyc_fcon,
   output logic [15:0]          cyc_tcon,
   output ebw_pkg::ebw_addr_t   cyc_addr
);
   import ebw_pkg::*;

   // ********************************
   // configuration registers
   // ********************************
   logic [6:0][15:0] sel;
   logic [7:0][15:0] fcon;
   logic [7:0][15:0] tcon;
   logic [15:0]      tcon_sm;
   logic [15:0]      tcon_mm;
   logic [15:0]      mode;
   logic [6:0][15:0] next_sel;
   logic [7:0][15:0] next_fcon;
   logic [7:0][15:0] next_tcon;
   logic [15:0]      next_tcon_sm;
   logic [15:0]      next_tcon_mm;
   logic [15:0]      next_mode;
   logic [15:0]      next_rdata;

   always_comb begin
      next_sel     = sel;
      next_fcon    = fcon;
      next_tcon    = tcon;
      next_tcon_sm = tcon_sm;
      next_tcon_mm = tcon_mm;
      next_mode    = mode;
      if (reg_wr) begin
         if (reg_addr < `EBW_OFS_SEL_BASE + 6'h07) begin
            next_sel[3'(reg_addr - `EBW_OFS_SEL_BASE)] = reg_wdata;
         end else if (reg_addr >= `EBW_OFS_FCON_BASE && reg_addr < `EBW_OFS_TCON_BASE) begin
            next_fcon[3'(reg_addr - `EBW_OFS_FCON_BASE)] = reg_wdata & `EBW_FCON_MASK;
         end else if (reg_addr >= `EBW_OFS_TCON_BASE && reg_addr < `EBW_OFS_MODE) begin
            next_tcon[3'(reg_addr - `EBW_OFS_TCON_BASE)] = reg_wdata & `EBW_TCON_MASK;
         end else if (reg_addr == `EBW_OFS_MODE) begin
            next_mode = {14'h0000, reg_wdata[1:0]};
         end else if (reg_addr == `EBW_OFS_TCON_SM) begin
            next_tcon_sm = reg_wdata & `EBW_TCON_MASK;
         end else if (reg_addr == `EBW_OFS_TCON_MM) begin
            next_tcon_mm = reg_wdata & `EBW_TCON_MASK;
         end
      end
   end

   // ********************************
   // window decode
   // ********************************
   ebw_cfg_if cfg ();
   logic [6:0] hit;
   logic [8:0] tag;
   logic       sm_hit;
   logic       mm_hit;

   always_comb begin
      cfg.sel  = sel;
      cfg.addr = req_addr;
      for (int i = 0; i < 7; i++) begin
         cfg.win_en[i] = fcon[i + 1][`EBW_FCON_WINDOW_SELECT_ENABLE];
      end
   end
   assign hit = cfg.hit;

   ebw_win_match u_match (
      .cfg (cfg.decoder)
   );

   // both fixed areas sit side by side, so the nine-bit tag tells them apart
   assign tag    = req_addr[23:15];
   assign sm_hit = tag == `EBW_SM_TAG;
   assign mm_hit = tag == `EBW_MM_TAG;

   // four-level arbitration
   // within one group the lowest window wins; overlaps there are a software fault
   logic [3:0] pick;
   always_comb begin
      pick = 4'hF;
      if (sm_hit) begin
         pick = 4'h8;
      end else if (mm_hit) begin
         pick = 4'h9;
      end else if (hit[1] || hit[3] || hit[5]) begin
         pick = hit[1] ? 4'h2 : (hit[3] ? 4'h4 : 4'h6);
      end else if (|{hit[0], hit[2], hit[4], hit[6]}) begin
         pick = hit[0] ? 4'h1 : (hit[2] ? 4'h3 : (hit[4] ? 4'h5 : 4'h7));
      end else if (fcon[0][`EBW_FCON_WINDOW_SELECT_ENABLE]) begin
         pick = 4'h0;
      end
   end

   // low address bits always reach the part; the select carries the top

   // ********************************
   // cycle control
   // ********************************
   ebw_state_e  state;
   ebw_state_e  next_state;
   logic [5:0]  cnt;
   logic [5:0]  next_cnt;
   logic        rdy_s1;
   logic        rdy_s2;
   logic [15:0] sel_f;
   logic [15:0] sel_t;
   logic        next_busy;
   logic        next_done;
   logic        next_refused;
   logic [9:0]  next_cs;
   logic [3:0]  next_chan;
   logic [15:0] next_fcon_o;
   logic [15:0] next_tcon_o;
   ebw_addr_t   next_caddr;

   // startup and monitor memories run without ready
   always_comb begin
      sel_f = 16'h0001;
      sel_t = tcon_sm;
      if (pick == 4'h9) begin
         sel_t = tcon_mm;
      end else if (pick < 4'h8) begin
         sel_f = fcon[pick[2:0]];
         sel_t = tcon[pick[2:0]];
      end
   end

   logic rdy_raw;
   logic rdy_use;
   // pin ignored while disabled: a ready cycle then hangs
   assign rdy_raw = !mode[`EBW_MODE_READY_PIN_DISABLE] && (ready_pin == mode[`EBW_MODE_READY_POLARITY]);
   // async path reads only the second synchroniser stage
   // sync path trusts the peripheral to meet setup and hold at the edge
   assign rdy_use = cyc_fcon[`EBW_FCON_WINDOW_READY_SYNC_MODE] ? rdy_raw : rdy_s2;

   always_comb begin
      next_state   = state;
      next_cnt     = cnt;
      next_busy    = cyc_busy;
      next_done    = 1'b0;
      next_refused = 1'b0;
      next_cs      = chip_sel;
      next_chan    = cyc_chan;
      next_fcon_o  = cyc_fcon;
      next_tcon_o  = cyc_tcon;
      next_caddr   = cyc_addr;
      unique case (state)
         EBW_IDLE: begin
            if (req_valid) begin
               if (pick == 4'hF) begin
                  next_refused = 1'b1;
               end else begin
                  next_state  = EBW_WAIT;
                  next_busy   = 1'b1;
                  next_chan   = pick;
                  next_fcon_o = sel_f;
                  next_tcon_o = sel_t;
                  next_caddr  = req_addr;
                  next_cs     = 10'(10'h001 << pick);
                  // phase E 1..32, one more when async ready
                  next_cnt    = {1'b0, sel_t[`EBW_TCON_PHE_HI:`EBW_TCON_PHE_LO]} +
                                ((sel_f[`EBW_FCON_WINDOW_READY_ENABLE] && !sel_f[`EBW_FCON_WINDOW_READY_SYNC_MODE])
                                 ? `EBW_ASYNC_EXTRA : 6'h00);
               end
            end
         end
         EBW_WAIT: begin
            if (cnt == 6'h00) begin
               if (!cyc_fcon[`EBW_FCON_WINDOW_READY_ENABLE] || rdy_use) begin
                  next_state = EBW_IDLE;
                  next_busy  = 1'b0;
                  next_done  = 1'b1;
                  next_cs    = 10'h000;
               end else begin
                  next_state = EBW_RDY;
               end
            end else begin
               next_cnt = 6'(cnt - 6'h01);
            end
         end
         EBW_RDY: begin
            // no timeout: a silent peripheral holds the bus until reset
            if (rdy_use) begin
               next_state = EBW_IDLE;
               next_busy  = 1'b0;
               next_done  = 1'b1;
               next_cs    = 10'h000;
            end
         end
         default: begin
            next_state = EBW_IDLE;
         end
      endcase
   end

   always_comb begin
      next_rdata = 16'h0000;
      if (reg_rd) begin
         if (reg_addr < `EBW_OFS_SEL_BASE + 6'h07) begin
            next_rdata = sel[3'(reg_addr - `EBW_OFS_SEL_BASE)];
         end else if (reg_addr >= `EBW_OFS_FCON_BASE && reg_addr < `EBW_OFS_TCON_BASE) begin
            next_rdata = fcon[3'(reg_addr - `EBW_OFS_FCON_BASE)];
         end else if (reg_addr >= `EBW_OFS_TCON_BASE && reg_addr < `EBW_OFS_MODE) begin
            next_rdata = tcon[3'(reg_addr - `EBW_OFS_TCON_BASE)];
         end else if (reg_addr == `EBW_OFS_MODE) begin
            next_rdata = mode;
         end else if (reg_addr == `EBW_OFS_STATUS) begin
            next_rdata = {10'h000, state, cyc_chan};
         end else if (reg_addr == `EBW_OFS_TCON_SM) begin
            next_rdata = tcon_sm;
         end else if (reg_addr == `EBW_OFS_TCON_MM) begin
            next_rdata = tcon_mm;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sel         <= '0;
         fcon        <= {{7{`EBW_FCONX_RESET}}, `EBW_FCON0_RESET};
         tcon        <= '0;
         tcon_sm     <= `EBW_TCON_RESET;
         tcon_mm     <= `EBW_TCON_RESET;
         mode        <= `EBW_MODE_RESET;
         reg_rdata   <= 16'h0000;
         state       <= EBW_IDLE;
         cnt         <= 6'h00;
         rdy_s1      <= 1'b0;
         rdy_s2      <= 1'b0;
         cyc_busy    <= 1'b0;
         cyc_done    <= 1'b0;
         cyc_refused <= 1'b0;
         chip_sel    <= 10'h000;
         cyc_chan    <= 4'h0;
         cyc_fcon    <= 16'h0000;
         cyc_tcon    <= 16'h0000;
         cyc_addr    <= 24'h000000;
      end else begin
         sel         <= next_sel;
         fcon        <= next_fcon;
         tcon        <= next_tcon;
         tcon_sm     <= next_tcon_sm;
         tcon_mm     <= next_tcon_mm;
         mode        <= next_mode;
         reg_rdata   <= next_rdata;
         state       <= next_state;
         cnt         <= next_cnt;
         rdy_s1      <= rdy_raw;
         rdy_s2      <= rdy_s1;
         cyc_busy    <= next_busy;
         cyc_done    <= next_done;
         cyc_refused <= next_refused;
         chip_sel    <= next_cs;
         cyc_chan    <= next_chan;
         cyc_fcon    <= next_fcon_o;
         cyc_tcon    <= next_tcon_o;
         cyc_addr    <= next_caddr;
      end
   end
endmodule

// [ebw_top_monitor.sv]
`timescale 1ns/10ps
// ****
// cycle checker
// ****
module ebw_top_monitor (
   input logic               sys_clk,
   input logic               rst,
   input logic               req_valid,
   input ebw_pkg::ebw_addr_t req_addr,
   input logic               cyc_busy,
   input logic               cyc_done,
   input logic               cyc_refused,
   input logic [9:0]         chip_sel,
   input logic [3:0]         cyc_chan,
   input logic [15:0]        cyc_fcon,
   input logic [15:0]        cyc_tcon,
   input ebw_pkg::ebw_addr_t cyc_addr
);
   import ebw_pkg::*;
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic [7:0] phe;
   logic       rdy_async;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // busy cycles seen before the current one; restarts after done for back-to-back starts
   always_comb begin
      next_cnt = (cyc_done || !cyc_busy) ? 8'h00 : cnt + 8'h01;
   end
   always_ff @(posedge sys_clk) begin
      cnt <= rst ? 8'h00 : next_cnt;
   end
   // phase E code n lasts n + 1 cycles
   assign phe = {3'h0, cyc_tcon[10:6]} + 8'h01;
   assign rdy_async = cyc_fcon[1] && !cyc_fcon[2] && (cyc_chan < 4'h8);
   sequence s_start;
      $rose(cyc_busy);
   endsequence
   sequence s_finish;
      ##[1:40] cyc_done;
   endsequence
   a_start_cause: assert property (s_start |-> $past(req_valid))
      else $error("cycle started without a request");
   a_addr_passed: assert property (s_start |-> cyc_addr == $past(req_addr))
      else $error("cycle address differs from request");
   a_done_bound: assert property (s_start ##0 (!cyc_fcon[1] || cyc_chan >= 4'h8) |-> s_finish)
      else $error("cycle without ready did not end in time");
   a_sel_chan: assert property (cyc_busy |-> chip_sel == (10'h001 << cyc_chan))
      else $error("chip select does not match channel");
   a_idle_quiet: assert property (!cyc_busy |-> chip_sel == 10'h000)
      else $error("chip select active while idle");
   a_fixed_window: assert property (cyc_busy && cyc_addr[23:15] == 9'h17E |-> cyc_chan == 4'h8)
      else $error("startup range routed elsewhere");
   a_refuse_idle: assert property (cyc_refused |-> !cyc_busy && chip_sel == 10'h000)
      else $error("refused request started a cycle");
   a_phe_count: assert property (cyc_done |-> cnt >= phe)
      else $error("cycle ended before wait count");
   a_async_extra: assert property (cyc_done && rdy_async |-> cnt >= phe + 8'h01)
      else $error("asynchronous ready missing extra wait");
   a_plain_length: assert property (cyc_done && !cyc_fcon[1] |-> cnt == phe)
      else $error("cycle without ready has wrong length");
endmodule

bind ebw_top ebw_top_monitor i_ebw_top_monitor (
   .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req_addr(req_addr), .cyc_busy(cyc_busy),
   .cyc_done(cyc_done), .cyc_refused(cyc_refused), .chip_sel(chip_sel), .cyc_chan(cyc_chan),
   .cyc_fcon(cyc_fcon), .cyc_tcon(cyc_tcon), .cyc_addr(cyc_addr)
);

// [ebw_ready_peer.sv]
`timescale 1ns/10ps
// ****
// external peripheral answering with ready
// ****
module ebw_ready_peer (
   input logic       sys_clk,
   input logic [9:0] chip_sel,
   input logic       pol,
   input logic       hang,
   input logic [3:0] lat,
   output logic      ready_pin
);
   logic [3:0] wait_cnt;
   logic [3:0] next_wait;
   logic       act;
   logic       next_act;
   always_comb begin
      next_wait = (chip_sel == 10'h000) ? 4'h0 : wait_cnt + {3'h0, wait_cnt != lat};
      // hang models a device that never answers
      next_act = (chip_sel != 10'h000) && (wait_cnt == lat) && !hang;
   end
   always_ff @(posedge sys_clk) begin
      wait_cnt <= next_wait;
      act <= next_act;
   end
   assign ready_pin = (act === 1'b1) ? pol : !pol;
endmodule

// [ext_bus_window_decode_ready_bench.sv]
`timescale 1ns/10ps
// ****
// bench
// ****
module ext_bus_window_decode_ready_bench;
   import ebw_pkg::*;
   logic        sys_clk, rst, reg_wr, reg_rd, req_valid, pol, hang, ready_pin;
   logic        cyc_busy, cyc_done, cyc_refused;
   logic        rd_d = 1'b0;
   logic [5:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, cyc_fcon, cyc_tcon;
   logic [9:0]  chip_sel;
   logic [3:0]  cyc_chan, lat;
   ebw_addr_t   req_addr, cyc_addr, a;
   int          fails = 0;
   int          checks = 0;
   int          span = 0;
   logic [27:0] exp_c;
   logic [15:0] rq[$];
   logic [27:0] cq[$];
   ebw_addr_t   ta[8] = '{24'h100123, 24'h108456, 24'h10FFFF, 24'h110000,
                          24'hBF0010, 24'hBF8010, 24'h200000, 24'h107FFF};
   logic [3:0]  tc[8] = '{4'h1, 4'h2, 4'h1, 4'h0, 4'h8, 4'h9, 4'h0, 4'h1};

   ebw_top i_ebw_top (
      .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid), .req_addr(req_addr),
      .ready_pin(ready_pin), .cyc_busy(cyc_busy), .cyc_done(cyc_done), .cyc_refused(cyc_refused),
      .chip_sel(chip_sel), .cyc_chan(cyc_chan), .cyc_fcon(cyc_fcon), .cyc_tcon(cyc_tcon),
      .cyc_addr(cyc_addr)
   );
   ebw_ready_peer i_ebw_ready_peer (
      .sys_clk(sys_clk), .chip_sel(chip_sel), .pol(pol), .hang(hang), .lat(lat), .ready_pin(ready_pin)
   );

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic chk(input string n, input logic [27:0] e, input logic [27:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   // strobes are set on every call so back-to-back accesses never assign twice
   task automatic wr(input logic [5:0] ad, input logic [15:0] d);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic rd(input logic [5:0] ad, input logic [15:0] e);
      rq.push_back(e);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic req(input ebw_addr_t ra, input logic [3:0] ch);
      cq.push_back({ch, ra});
      req_addr <= ra;
      req_valid <= 1'b1;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      req_valid <= 1'b0;
   endtask

   task automatic wait_end;
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (!(cyc_done === 1'b1 || cyc_refused === 1'b1) && n < 200);
      span = n;
      if (n >= 200) begin
         fails++;
         $display("[FAIL] cycle_end expected 1 seen 0");
      end
   endtask

   task automatic test_done;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // refused requests carry channel code F in the notes
   always @(posedge sys_clk) begin
      if (rd_d)
         chk("reg_rdata", {12'h000, rq.pop_front()}, {12'h000, reg_rdata});
      rd_d = (reg_rd === 1'b1);
      if (cyc_done === 1'b1 || cyc_refused === 1'b1) begin
         exp_c = cq.pop_front();
         chk("chan_addr", exp_c, cyc_refused ? {4'hF, exp_c[23:0]} : {cyc_chan, cyc_addr});
      end
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      test_done;
   end

   initial begin
      rst = 1'b1;
      reg_addr = 6'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      req_valid = 1'b0;
      req_addr = 24'h000000;
      pol = 1'b0;
      hang = 1'b0;
      lat = 4'h3;
      void'($urandom(68218));
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rd(6'h08, 16'h0021);
      rd(6'h18, 16'h0001);
      rd(6'h00, 16'h0000);
      wr(6'h09, 16'hFFFF);
      rd(6'h09, 16'h0037);
      wr(6'h11, 16'hFFFF);
      rd(6'h11, 16'h7FFF);
      wr(6'h1C, 16'hFFFF);
      rd(6'h1C, 16'h0000);
      wr(6'h00, 16'h10F4);
      wr(6'h01, 16'h1080);
      wr(6'h06, 16'h200C);
      wr(6'h09, 16'h0001);
      wr(6'h0A, 16'h0001);
      wr(6'h0F, 16'h0001);
      wr(6'h11, 16'h0080);
      for (int i = 0; i < 8; i++) begin
         req(ta[i], tc[i]);
         wait_end;
      end
      repeat (4) begin
         a = 24'h100000 | ($urandom & 24'h007FFF);
         req(a, 4'h1);
         wait_end;
         chk("cycle_span", 28'h0000004, 28'(span));
      end
      wr(6'h0A, 16'h0000);
      req(24'h108456, 4'h1);
      wait_end;
      wr(6'h08, 16'h0000);
      req(24'h300000, 4'hF);
      wait_end;
      wr(6'h08, 16'h0021);
      wr(6'h18, 16'h0000);
      wr(6'h09, 16'h0003);
      req(24'h100040, 4'h1);
      wait_end;
      chk("cycle_span", 28'h0000008, 28'(span));
      pol <= 1'b1;
      wr(6'h18, 16'h0002);
      wr(6'h09, 16'h0007);
      req(24'h100060, 4'h1);
      wait_end;
      chk("cycle_span", 28'h0000006, 28'(span));
      hang <= 1'b1;
      req(24'h100080, 4'h1);
      repeat (60) @(posedge sys_clk);
      chk("cyc_busy", 28'h0000001, {27'h0, cyc_busy});
      hang <= 1'b0;
      wait_end;
      test_done;
   end
endmodule
